// file: hw/watchdog_interval_timer.sv
// Watchdog and interval timer with keyed register writes and standby recovery timing.
// Assumes a single 250 MHz clock, a synchronous active-low reset taken from the external reset pin,
// and a register master that never issues read and write together.
//
// Summary of operation
// - Watchdog only with mode and run set
// - Overflow output low for 512 cycles
// - Internal reset starts with overflow output
// - Type bit picks power-on or manual
// - Internal reset lasts 2048 cycles
// - External reset wins, clears watchdog flag
// - Interval mode requests interrupt each overflow
// - Interval overflow sets interval flag
// - Watchdog overflow sets flag, drives output
// - Standby refused while counter runs
// - Wake counts at old rate, wrap ends standby
// - Count write beats simultaneous increment
// - Watchdog without reset clears count, control
// - Run clear stops and zeroes count
// - Three-bit select picks one of eight dividers
// - Keyed 16-bit writes, key in upper byte
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module watchdog_interval_timer (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire wdt_pkg::reg_req_s req_i,
	output logic [7:0] rdata_o,
	input wire logic standby_req_i,
	input wire logic nmi_i,
	output logic standby_o,
	output logic clock_run_o,
	output logic interval_irq_o,
	output logic overflow_out_n_o,
	output wdt_pkg::chip_reset_s chip_reset_o
);
	import wdt_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] watchdog_count_q;
	logic interval_overflow_flag_q;
	logic timer_mode_select_q;
	logic counter_run_enable_q;
	logic [2:0] clock_divider_select_q;
	logic watchdog_overflow_flag_q;
	logic internal_reset_enable_q;
	logic reset_type_select_q;
	logic [PRESC_W-1:0] presc_q;
	logic [10:0] ovf_cnt_q;
	logic ovf_active_q;
	logic [10:0] rst_cnt_q;
	logic nmi_s1_q;
	logic nmi_s2_q;
	logic standby_q;
	logic wake_q;

	logic wr_cnt;
	logic wr_csr;
	logic wr_rst_fields;
	logic wr_flag_clr;
	logic tick;
	logic counting;
	logic overflow;
	logic wdt_overflow;
	logic itv_overflow;
	logic wdt_soft_reset;

	// Keyed writes: anything else at the write offsets is ignored
	assign wr_cnt = req_i.wr && req_i.addr == OFS_CNT_CSR_WR && req_i.wdata[15:8] == KEY_CNT;
	assign wr_csr = req_i.wr && req_i.addr == OFS_CNT_CSR_WR && req_i.wdata[15:8] == KEY_CSR;
	assign wr_rst_fields = req_i.wr && req_i.addr == OFS_RST_WR && req_i.wdata[15:8] == KEY_RST_FIELDS;
	assign wr_flag_clr = req_i.wr && req_i.addr == OFS_RST_WR && req_i.wdata[15:8] == KEY_FLAG_CLR
		&& req_i.wdata[7:0] == FLAG_CLR_DATA;

	// ----------------------------------------
	// Prescaler and tick select
	// ----------------------------------------
	// Counter runs when enabled, or during standby wake-up
	assign counting = counter_run_enable_q || wake_q;

	always_ff @(posedge clock_i) begin
		if (!nrst_i || !counting) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 1'b1;
		end
	end

	always_comb begin
		case (clock_divider_select_q)
			3'h0: tick = counting && presc_q[1:0] == 2'h3;
			3'h1: tick = counting && presc_q[6:0] == 7'h7f;
			3'h2: tick = counting && presc_q[7:0] == 8'hff;
			3'h3: tick = counting && presc_q[8:0] == 9'h1ff;
			3'h4: tick = counting && presc_q[9:0] == 10'h3ff;
			3'h5: tick = counting && presc_q[10:0] == 11'h7ff;
			3'h6: tick = counting && presc_q[12:0] == 13'h1fff;
			3'h7: tick = counting && presc_q[13:0] == 14'h3fff;
			default: tick = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Counter and overflow
	// ----------------------------------------
	assign overflow = tick && !wr_cnt && watchdog_count_q == 8'hff;
	assign wdt_overflow = overflow && counter_run_enable_q && timer_mode_select_q;
	assign itv_overflow = overflow && counter_run_enable_q && !timer_mode_select_q;
	assign wdt_soft_reset = wdt_overflow && !internal_reset_enable_q;

	always_ff @(posedge clock_i) begin
		if (!nrst_i || wdt_soft_reset) begin
			watchdog_count_q <= CNT_RESET;
		end else if (!counting) begin
			watchdog_count_q <= CNT_RESET;
		end else if (wr_cnt) begin
			watchdog_count_q <= req_i.wdata[7:0];
		end else if (tick) begin
			watchdog_count_q <= watchdog_count_q + 1'b1;
		end
	end

	// Control register; a watchdog overflow without chip reset clears it too
	always_ff @(posedge clock_i) begin
		if (!nrst_i || wdt_soft_reset) begin
			timer_mode_select_q <= 1'b0;
			counter_run_enable_q <= 1'b0;
			clock_divider_select_q <= DIV_RESET;
		end else if (wr_csr) begin
			timer_mode_select_q <= req_i.wdata[CSR_MODE_BIT];
			counter_run_enable_q <= req_i.wdata[CSR_RUN_BIT];
			clock_divider_select_q <= req_i.wdata[2:0];
		end
	end

	// Interval flag: set beats a software clear in the same cycle
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			interval_overflow_flag_q <= 1'b0;
		end else if (itv_overflow) begin
			interval_overflow_flag_q <= 1'b1;
		end else if (wdt_soft_reset) begin
			interval_overflow_flag_q <= 1'b0;
		end else if (wr_csr && !req_i.wdata[CSR_OVF_BIT]) begin
			interval_overflow_flag_q <= 1'b0;
		end
	end

	assign interval_irq_o = interval_overflow_flag_q;

	// ----------------------------------------
	// Reset control and status
	// ----------------------------------------
	// External reset clears the flag even if an overflow lands on the same edge
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			watchdog_overflow_flag_q <= 1'b0;
		end else if (wdt_overflow) begin
			watchdog_overflow_flag_q <= 1'b1;
		end else if (wr_flag_clr) begin
			watchdog_overflow_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			internal_reset_enable_q <= 1'b0;
			reset_type_select_q <= 1'b0;
		end else if (wr_rst_fields) begin
			internal_reset_enable_q <= req_i.wdata[RST_EN_BIT];
			reset_type_select_q <= req_i.wdata[RST_TYPE_BIT];
		end
	end

	// ----------------------------------------
	// Overflow output and internal reset pulses
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			ovf_active_q <= 1'b0;
			ovf_cnt_q <= '0;
		end else if (wdt_overflow) begin
			ovf_active_q <= 1'b1;
			ovf_cnt_q <= '0;
		end else if (ovf_active_q) begin
			ovf_cnt_q <= ovf_cnt_q + 1'b1;
			if (ovf_cnt_q == OVF_OUT_LAST) begin
				ovf_active_q <= 1'b0;
			end
		end
	end

	assign overflow_out_n_o = !ovf_active_q;

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			chip_reset_o <= '0;
			rst_cnt_q <= '0;
		end else if (wdt_overflow && internal_reset_enable_q) begin
			chip_reset_o.active <= 1'b1;
			chip_reset_o.manual <= reset_type_select_q;
			rst_cnt_q <= '0;
		end else if (chip_reset_o.active) begin
			rst_cnt_q <= rst_cnt_q + 1'b1;
			if (rst_cnt_q == INT_RST_LAST) begin
				chip_reset_o <= '0;
			end
		end
	end

	// ----------------------------------------
	// Standby entry and NMI wake-up
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			nmi_s1_q <= 1'b0;
			nmi_s2_q <= 1'b0;
		end else begin
			nmi_s1_q <= nmi_i;
			nmi_s2_q <= nmi_s1_q;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			standby_q <= 1'b0;
			wake_q <= 1'b0;
		end else if (!standby_q) begin
			if (standby_req_i && !counter_run_enable_q) begin
				standby_q <= 1'b1;
			end
		end else if (!wake_q) begin
			if (nmi_s2_q) begin
				wake_q <= 1'b1;
			end
		end else if (tick && watchdog_count_q == 8'hff) begin
			standby_q <= 1'b0;
			wake_q <= 1'b0;
		end
	end

	assign standby_o = standby_q;
	assign clock_run_o = !standby_q;

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rdata_o <= 8'h00;
		end else if (req_i.rd) begin
			case (req_i.addr)
				OFS_CSR_RD: rdata_o <= {interval_overflow_flag_q, timer_mode_select_q, counter_run_enable_q,
					2'b11, clock_divider_select_q};
				OFS_CNT_RD: rdata_o <= watchdog_count_q;
				OFS_RST_RD: rdata_o <= {watchdog_overflow_flag_q, internal_reset_enable_q, reset_type_select_q,
					5'h1f};
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [11:0] low_len_q;
	always_ff @(posedge clock_i) begin
		if (!nrst_i || overflow_out_n_o) begin
			low_len_q <= '0;
		end else begin
			low_len_q <= low_len_q + 1'b1;
		end
	end

	// High-time counter for the internal reset; a fresh trigger restarts it
	logic [11:0] hi_len_q;
	always_ff @(posedge clock_i) begin
		if (!nrst_i || !chip_reset_o.active || (wdt_overflow && internal_reset_enable_q)) begin
			hi_len_q <= '0;
		end else begin
			hi_len_q <= hi_len_q + 1'b1;
		end
	end

	// A pulse cut short by the external reset is not a length violation
	ovf_pulse_len_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		($rose(overflow_out_n_o) && $past(nrst_i)) |-> $past(low_len_q) == 12'(OVF_OUT_CYCLES - 1))
		else $error("overflow output low time wrong");
	ovf_start_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		wdt_overflow |=> !overflow_out_n_o && watchdog_overflow_flag_q)
		else $error("watchdog overflow did not drive output and flag");
	reset_with_ovf_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(wdt_overflow && internal_reset_enable_q) |=> chip_reset_o.active && $fell(overflow_out_n_o))
		else $error("internal reset not with overflow output");
	reset_type_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(wdt_overflow && internal_reset_enable_q) |=> chip_reset_o.manual == $past(reset_type_select_q))
		else $error("internal reset type wrong");
	reset_len_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		($fell(chip_reset_o.active) && $past(nrst_i)) |-> $past(hi_len_q) == 12'(INT_RST_CYCLES - 1))
		else $error("internal reset length wrong");
	itv_flag_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		itv_overflow |=> interval_overflow_flag_q && interval_irq_o && overflow_out_n_o)
		else $error("interval overflow flag not set");
	wdt_mode_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!timer_mode_select_q |=> !$fell(overflow_out_n_o))
		else $error("overflow output outside watchdog mode");
	write_wins_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(wr_cnt && counter_run_enable_q && !wdt_soft_reset) |=> watchdog_count_q == $past(req_i.wdata[7:0]))
		else $error("count write lost");
	stop_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!counting |=> watchdog_count_q == CNT_RESET)
		else $error("stopped counter not zero");
	standby_refuse_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(!standby_q && counter_run_enable_q) |=> !standby_q)
		else $error("standby entered while running");
	soft_reset_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		wdt_soft_reset |=> watchdog_count_q == CNT_RESET && !counter_run_enable_q && !chip_reset_o.active)
		else $error("watchdog overflow without reset mishandled");
	rst_flag_a: assert property (@(posedge clock_i)
		!nrst_i |=> !watchdog_overflow_flag_q)
		else $error("external reset left watchdog flag set");
	wake_end_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		($fell(standby_q) && $past(nrst_i)) |-> $past(wake_q) && $past(tick) && $past(watchdog_count_q) == 8'hff)
		else $error("standby ended without counter wrap");
	key_guard_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(req_i.wr && req_i.wdata[15:8] != KEY_CSR && !wdt_soft_reset) |=> $stable(counter_run_enable_q))
		else $error("control changed without its key");
	div_spacing_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
		tick |=> !tick ##1 !tick ##1 !tick)
		else $error("count pulses closer than four cycles");

	wdt_ovf_c: cover property (@(posedge clock_i) disable iff (!nrst_i) wdt_overflow && internal_reset_enable_q);
	itv_ovf_c: cover property (@(posedge clock_i) disable iff (!nrst_i) itv_overflow);
	wake_end_c: cover property (@(posedge clock_i) disable iff (!nrst_i) $fell(standby_q));
	write_tick_c: cover property (@(posedge clock_i) disable iff (!nrst_i) wr_cnt && tick);
	stby_refused_c: cover property (@(posedge clock_i) disable iff (!nrst_i) standby_req_i && counter_run_enable_q);

endmodule : watchdog_interval_timer

// file: hw/wdt_pkg.sv
// Package for the watchdog and interval timer: register offsets, keys, field positions, reset values, timing counts.
// Assumes one 250 MHz clock and a plain strobe register port with 16-bit write data.
package wdt_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses on the register port)
	// ----------------------------------------
	localparam logic [1:0] OFS_CNT_CSR_WR = 2'h0; // Write: count or control, selected by key
	localparam logic [1:0] OFS_CSR_RD = 2'h0;
	localparam logic [1:0] OFS_CNT_RD = 2'h1;
	localparam logic [1:0] OFS_RST_WR = 2'h2;
	localparam logic [1:0] OFS_RST_RD = 2'h3;

	// ----------------------------------------
	// Write keys in the upper byte
	// ----------------------------------------
	localparam logic [7:0] KEY_CNT = 8'h5a;
	localparam logic [7:0] KEY_CSR = 8'ha5;
	localparam logic [7:0] KEY_RST_FIELDS = 8'h5a;
	localparam logic [7:0] KEY_FLAG_CLR = 8'ha5;
	localparam logic [7:0] FLAG_CLR_DATA = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CSR_OVF_BIT = 7;
	localparam int CSR_MODE_BIT = 6;
	localparam int CSR_RUN_BIT = 5;
	localparam int RST_FLAG_BIT = 7;
	localparam int RST_EN_BIT = 6;
	localparam int RST_TYPE_BIT = 5;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] CSR_RESERVED = 8'h18;
	localparam logic [7:0] RST_RESERVED = 8'h1f;
	localparam logic [2:0] DIV_RESET = 3'h0;

	// ----------------------------------------
	// Timing counts
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int OVF_OUT_CYCLES = 512;
	localparam int INT_RST_CYCLES = 2048;
	localparam logic [10:0] OVF_OUT_LAST = 11'(OVF_OUT_CYCLES - 1);
	localparam logic [10:0] INT_RST_LAST = 11'(INT_RST_CYCLES - 1);
	localparam int PRESC_W = 14;

	typedef struct packed {
		logic [1:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic active;
		logic manual;
	} chip_reset_s;

endpackage : wdt_pkg

// file: tb/sys_reset_model.sv
// Model of the system reset circuit that listens to the timer's overflow output.
// Assumes the timer's clock; reports the width of the last low pulse and the pulse count.
`timescale 1ns/1ps

module sys_reset_model (
	input wire logic clock_i,
	input wire logic overflow_out_n_i,
	output int low_len_o,
	output int events_o
);
	int run_len_q = 0;
	int low_len_q = 0;
	int events_q = 0;

	// ----------------------------------------
	// Pulse width capture
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (overflow_out_n_i === 1'b0) begin
			run_len_q <= run_len_q + 1;
		end else if (run_len_q != 0) begin
			low_len_q <= run_len_q;
			events_q <= events_q + 1;
			run_len_q <= 0;
		end
	end

	assign low_len_o = low_len_q;
	assign events_o = events_q;
endmodule : sys_reset_model

// file: tb/tb_top.sv
// Self-checking bench for the watchdog and interval timer.
// Assumes wdt_pkg, the timer and the reset-circuit model sys_reset_model.
`timescale 1ns/1ps

module tb_top;
	import wdt_pkg::*;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	reg_req_s req = '0;
	logic standby_req = 1'b0;
	logic nmi = 1'b0;
	logic [7:0] rdata;
	logic standby, clock_run, irq, ovf_n;
	chip_reset_s chip_rst;
	int low_len, events, n;
	int n_errors = 0;
	int comparisons = 0;
	logic [7:0] v;

	watchdog_interval_timer watchdog_interval_timer_i (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req),
		.rdata_o(rdata), .standby_req_i(standby_req), .nmi_i(nmi), .standby_o(standby),
		.clock_run_o(clock_run), .interval_irq_o(irq), .overflow_out_n_o(ovf_n), .chip_reset_o(chip_rst));
	sys_reset_model sys_reset_model_i (.clock_i(clock_i), .overflow_out_n_i(ovf_n), .low_len_o(low_len),
		.events_o(events));

	initial begin
		forever #2 clock_i = ~clock_i;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic close_out;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clock_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock_i);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string name);
		@(posedge clock_i);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock_i);
		req.rd <= 1'b0;
		#1;
		chk(name, {8'h00, exp}, {8'h00, rdata});
	endtask : rd

	// Waits for ovf_n (0), irq (1) or standby (2) to reach lvl
	task automatic wait_lvl(input int which, input logic lvl, input int lim, output int cnt);
		logic s;
		cnt = 0;
		s = (which == 0) ? ovf_n : (which == 1) ? irq : standby;
		while (s !== lvl && cnt < lim) begin
			@(posedge clock_i);
			#1;
			cnt++;
			s = (which == 0) ? ovf_n : (which == 1) ? irq : standby;
		end
		chk("wait bound", 16'h0001, 16'(cnt < lim));
	endtask : wait_lvl

	task automatic stby(input logic exp);
		@(posedge clock_i);
		standby_req <= 1'b1;
		@(posedge clock_i);
		standby_req <= 1'b0;
		#1;
		chk("standby", 16'(exp), 16'(standby));
		chk("clock run", 16'(!exp), 16'(clock_run));
	endtask : stby

	function automatic int div_of(input int c);
		int t[8] = '{4, 128, 256, 512, 1024, 2048, 8192, 16384};
		return t[c];
	endfunction : div_of

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h7272));
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		rd(OFS_CSR_RD, 8'h18, "csr reset");
		rd(OFS_RST_RD, 8'h1f, "rst reset");
		rd(2'h2, 8'h00, "unmapped read");
		rd(OFS_CNT_RD, 8'h00, "count reset");
		// Count is held at zero while stopped: run at the slowest rate, no pulse falls in this loop
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h3f});
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			wr(OFS_CNT_CSR_WR, {KEY_CNT, v});
			wr(OFS_CNT_CSR_WR, {KEY_CNT ^ (8'h01 << i), ~v});
			rd(OFS_CNT_RD, v, "count keyed");
		end
		for (int c = 0; c < 8; c++) begin
			wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h18});
			rd(OFS_CNT_RD, 8'h00, "stop zeroes");
			wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h20 | 8'(c)});
			repeat (div_of(c) * 5 / 2 - 2) @(posedge clock_i);
			rd(OFS_CNT_RD, 8'h02, "divider ticks");
		end
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h00});
		v = 8'hf0 | 8'($urandom % 16);
		// Start first, then load the count, two cycles before the first count pulse
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h20});
		wr(OFS_CNT_CSR_WR, {KEY_CNT, v});
		wait_lvl(1, 1'b1, 80, n);
		chk("no output in interval", 16'h0001, 16'(ovf_n));
		rd(OFS_CSR_RD, 8'hb8, "interval flag");
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h20});
		#1;
		chk("irq clear", 16'h0000, 16'(irq));
		@(posedge clock_i);
		req <= '{addr: OFS_CNT_CSR_WR, wdata: {KEY_CNT, 8'hff}, wr: 1'b1, rd: 1'b0};
		repeat (40) begin
			@(posedge clock_i);
			#1;
			chk("write beats tick", 16'h0000, 16'(irq));
		end
		@(posedge clock_i);
		req.wr <= 1'b0;
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h00});
		wr(OFS_RST_WR, {KEY_RST_FIELDS, 8'h60});
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h61});
		wr(OFS_CNT_CSR_WR, {KEY_CNT, 8'hfe});
		wait_lvl(0, 1'b0, 400, n);
		chk("reset with output", 16'h0001, 16'(chip_rst.active));
		chk("reset type", 16'h0001, 16'(chip_rst.manual));
		n = 0;
		while (chip_rst.active === 1'b1 && n < 3000) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		chk("reset length", 16'(INT_RST_CYCLES), 16'(n));
		chk("output length", 16'(OVF_OUT_CYCLES), 16'(low_len));
		chk("output pulses", 16'h0001, 16'(events));
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h00});
		rd(OFS_RST_RD, 8'hff, "watchdog flag");
		wr(OFS_RST_WR, {KEY_FLAG_CLR, FLAG_CLR_DATA});
		rd(OFS_RST_RD, 8'h7f, "flag clear");
		wr(OFS_RST_WR, {KEY_RST_FIELDS, 8'h00});
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h61});
		wr(OFS_CNT_CSR_WR, {KEY_CNT, 8'hfe});
		wait_lvl(0, 1'b0, 400, n);
		chk("no chip reset", 16'h0000, 16'(chip_rst.active));
		rd(OFS_CSR_RD, 8'h18, "control cleared");
		rd(OFS_CNT_RD, 8'h00, "count cleared");
		@(posedge clock_i);
		nrst_i <= 1'b0;
		@(posedge clock_i);
		nrst_i <= 1'b1;
		#1;
		chk("reset ends output", 16'h0001, 16'(ovf_n));
		rd(OFS_RST_RD, 8'h1f, "reset clears flag");
		chk("output pulses", 16'h0002, 16'(events));
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h20});
		stby(1'b0);
		wr(OFS_CNT_CSR_WR, {KEY_CSR, 8'h00});
		stby(1'b1);
		@(posedge clock_i);
		nmi <= 1'b1;
		wait_lvl(2, 1'b0, 1200, n);
		chk("wake span", 16'h0001, 16'(n >= 1024 && n <= 1032));
		chk("clock back", 16'h0001, 16'(clock_run));
		@(posedge clock_i);
		nmi <= 1'b0;
		close_out();
	end

	initial begin
		#(95000 * 4);
		n_errors++;
		close_out();
	end
endmodule : tb_top
